// *** verification/hbap_host_model.sv ***
`timescale 1ns/100ps
module hbap_host_model (
	// clock and acknowledge polarity
	input  wire logic        clk_sys,
	input  wire logic        ack_hi,
	// processor and dma pins
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic [17:0]      addr,
	output logic [31:0]      data_in,
	input  wire logic [31:0] data_out,
	output logic             dma_acknowledge
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 18'h00400;
		data_in = 32'hffff_ffff;
		dma_acknowledge = 1'b0;
	end
	// one strobe held six cycles, then six idle cycles
	task automatic cyc(input logic dma, input logic we, input logic [17:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		cs_n <= dma;
		addr <= a;
		data_in <= d;
		rd_n <= we;
		wr_n <= ~we;
		repeat (6) @(posedge clk_sys);
		q = data_out;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		// released lines show the inverse, not the last value
		data_in <= ~d;
		repeat (6) @(posedge clk_sys);
	endtask : cyc
	task automatic ack(input logic on);
		@(posedge clk_sys);
		dma_acknowledge <= on ~^ ack_hi;
		repeat (6) @(posedge clk_sys);
	endtask : ack
endmodule : hbap_host_model

// *** verification/tb_host_buffer_access_port.sv ***
`timescale 1ns/100ps
module tb_host_buffer_access_port;
	import hbap_pkg::*;
	logic                  clk_sys = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  cs_n, rd_n, wr_n, dma_acknowledge, data_oe, dma_request, reg_wr, reg_rd;
	logic [17:0]           addr;
	logic [31:0]           data_in, data_out, q, reg_wdata;
	logic [31:0]           hw_mode = 32'h0000_0160;
	logic [31:0]           dma_cfg = 32'h0;
	logic [31:0]           irq_enable = 32'h0;
	logic [31:0]           reg_rdata = 32'h5a5a_0308;
	logic [15:0]           dma_start_addr = 16'h0, reg_addr;
	logic [16:0]           dma_length = 17'h0;
	logic [6:0]            dma_burst_bytes = 7'h4;
	logic                  dma_complete_irq_bit, dma_busy, eng_grant, eng_rvalid;
	hbap_region_t          mem_region;
	logic                  eng_req = 1'b0;
	logic                  eng_we = 1'b0;
	logic [HBAP_IDX_W-1:0] eng_idx = 13'h0;
	logic [63:0]           eng_wdata = 64'h0, eng_rdata;
	logic [7:0]            eng_be = 8'h0;
	int                    n_mismatch = 0, total_checks = 0, n_irq = 0, n_wr = 0, n_rd = 0;

	hbap_port DUT (.clk_sys, .reset_n, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
		.dma_request, .dma_acknowledge, .hw_mode, .dma_cfg, .dma_start_addr, .dma_length,
		.dma_burst_bytes, .irq_enable, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.dma_complete_irq_bit, .dma_busy, .mem_region, .eng_req, .eng_we, .eng_idx, .eng_wdata,
		.eng_be, .eng_grant, .eng_rvalid, .eng_rdata);
	hbap_host_model host (.clk_sys, .ack_hi(hw_mode[6]), .cs_n, .rd_n, .wr_n, .addr, .data_in,
		.data_out, .dma_acknowledge);

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_irq <= n_irq + int'(dma_complete_irq_bit === 1'b1);
		n_wr <= n_wr + int'(reg_wr === 1'b1);
		n_rd <= n_rd + int'(reg_rd === 1'b1);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic act(input logic on);
		return on ~^ hw_mode[5];
	endfunction : act
	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		host.cyc(1'b0, 1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [17:0] a);
		host.cyc(1'b0, 1'b0, a, 32'h0, q);
	endtask : rd
	task automatic dma_go(input logic w, input logic [15:0] sa, input logic [16:0] len, input logic [6:0] bb);
		@(posedge clk_sys);
		dma_cfg <= {31'h0, w};
		dma_start_addr <= sa;
		dma_length <= len;
		dma_burst_bytes <= bb;
		@(posedge clk_sys);
		dma_cfg <= {30'h0, 1'b1, w};
		repeat (6) @(posedge clk_sys);
	endtask : dma_go

	task automatic t_reset;
		check(data_oe, 1'b0);
		check(dma_busy, 1'b0);
		check(dma_request, 1'b0);
		check(eng_grant, 1'b0);
		rd(18'h0033c);
		check(q, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_map;
		for (int i = 0; i < 4; i++) begin
			wr({2'h0, 16'(16'h0400 * (i + 1))}, 32'h0);
			check(mem_region, 64'(i));
			wr({2'h0, 16'(16'h4000 + 4 * i)}, {16'hc0de, 16'(i)});
			wr({2'h0, 16'(16'h4100 + 4 * i)}, {16'hbeef, 16'(i)});
		end
		wr(18'h05104, 32'hffff_ffff);
		$display("map test done");
	endtask : t_map
	task automatic t_prefetch;
		eng_idx <= 13'h780;
		eng_req <= 1'b1;
		wr(18'h0033c, 32'h0001_4000);
		wr(18'h0033c, 32'h0002_4100);
		check(eng_rvalid, 1'b1);
		check(eng_rdata, {16'hc0de, 16'h1, 16'hc0de, 16'h0});
		rd(18'h0033c);
		check(q, 32'h0002_4100);
		for (int i = 0; i < 3; i++) begin
			rd({2'h1, 16'h0400});
			check(q, {16'hc0de, 16'(i)});
		end
		for (int i = 0; i < 2; i++) begin
			rd({2'h2, 16'h0800});
			check(q, {16'hbeef, 16'(i)});
		end
		rd({2'h1, 16'hfff8});
		check(q, {16'hc0de, 16'h3});
		eng_req <= 1'b0;
		$display("prefetch test done");
	endtask : t_prefetch
	task automatic t_reg;
		wr(18'h00304, 32'h1234_5678);
		check(reg_addr, 16'h0304);
		check(reg_wdata, 32'h1234_5678);
		rd(18'h00308);
		check(q, 32'h5a5a_0308);
		check(n_wr, 1);
		check(n_rd, 1);
		$display("register test done");
	endtask : t_reg
	task automatic t_dma32;
		irq_enable <= 32'h0000_0008;
		dma_go(1'b1, 16'h5000, 17'h8, 7'h4);
		check(dma_request, act(1'b1));
		for (int b = 0; b < 2; b++) begin
			host.ack(1'b1);
			host.cyc(1'b1, 1'b1, 18'h00400, {16'hd0a0, 16'(b)}, q);
			check(dma_request, act(1'b0));
			host.ack(1'b0);
			check(dma_request, act(b == 0));
			if (b == 0) wr(18'h06000, 32'h0);
		end
		check(n_irq, 1);
		check(dma_busy, 1'b0);
		wr(18'h0033c, 32'h0000_5000);
		for (int i = 0; i < 2; i++) begin
			rd(18'h00400);
			check(q, {16'hd0a0, 16'(i)});
		end
		$display("dma32 test done");
	endtask : t_dma32
	task automatic t_dma_rd;
		dma_go(1'b0, 16'h5000, 17'h8, 7'h4);
		for (int b = 0; b < 2; b++) begin
			check(dma_request, act(1'b1));
			host.ack(1'b1);
			host.cyc(1'b1, 1'b0, 18'h00400, 32'h0, q);
			check(q, {16'hd0a0, 16'(b)});
			check(dma_request, act(1'b0));
			host.ack(1'b0);
		end
		check(dma_request, act(1'b0));
		check(n_irq, 2);
		$display("dma read test done");
	endtask : t_dma_rd
	task automatic t_dma16;
		hw_mode <= 32'h0;
		irq_enable <= 32'h0;
		host.ack(1'b0);
		dma_go(1'b1, 16'h5100, 17'h7, 7'h8);
		check(dma_request, 1'b0);
		host.ack(1'b1);
		for (int i = 0; i < 4; i++) begin
			host.cyc(1'b1, 1'b1, 18'h00400, {16'hffff, 16'(16'h1111 * (i + 1))}, q);
			check(dma_request, act(i < 3));
		end
		host.ack(1'b0);
		check(dma_request, act(1'b0));
		check(n_irq, 2);
		wr(18'h0033c, 32'h0000_5100);
		wr(18'h0033e, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			rd({2'h3, 16'h0400});
			check(q, {16'h0, i < 3 ? 16'(16'h1111 * (i + 1)) : 16'hff44});
		end
		rd(18'h00308);
		check(q, 32'h0000_0308);
		rd(18'h0030a);
		check(q, 32'h0000_5a5a);
		$display("dma16 test done");
	endtask : t_dma16

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_map();
		t_prefetch();
		t_reg();
		t_dma32();
		t_dma_rd();
		t_dma16();
		summarize();
	end
endmodule : tb_host_buffer_access_port

// *** verilog/hbap_pkg.sv ***
// Contract
// - word index = (address - 0400h) >> 3
// - iso, int, async descriptor areas, then payload
// - arbiter shares 64-bit RAM with engine
// - bit 8 of mode selects 16/32 bus
// - chip select for pio, acknowledge for dma
// - request asserts once dma is enabled; dma reads raise it only after the first dword is fetched
// - prefetch register write loads bank pointer
// - bank reads return next dword, advance four
// - A[17:16] picks bank, own pointer each
// - memory writes take given address, no increment
// - register accesses take exact address, no increment
// - bursts of 1, 4, 8, 16 cycles
// - request drops on last burst strobe, reasserts
// - request stays low after byte count ends
// - request and acknowledge polarities are selectable
// - pio between bursts keeps dma counters
// - completion drops request, optional interrupt bit 3
// - burst size in bytes, cycles by width
// - odd length rounded outside, exact bytes written
package hbap_pkg;
	localparam logic [15:0] HBAP_MEM_BASE      = 16'h0400;
	localparam logic [15:0] HBAP_INT_BASE      = 16'h0800;
	localparam logic [15:0] HBAP_ASYNC_BASE    = 16'h0c00;
	localparam logic [15:0] HBAP_PAYLOAD_BASE  = 16'h1000;
	localparam logic [15:0] HBAP_PREFETCH_OFS  = 16'h033c;
	localparam logic [31:0] HBAP_PREFETCH_RST  = 32'h0000_0000;
	localparam int          HBAP_RAM_WORDS     = 8192;
	localparam int          HBAP_IDX_W         = 13;
	localparam int          HBAP_BUS32_BIT     = 8;
	localparam int          HBAP_DMA_REQUEST_HI_BIT   = 5;
	localparam int          HBAP_DMA_ACKNOWLEDGE_HI_BIT   = 6;
	localparam int          HBAP_DMA_WR_BIT    = 0;
	localparam int          HBAP_DMA_EN_BIT    = 1;
	localparam int          HBAP_DMA_IRQ_BIT   = 3;
	localparam logic [2:0]  HBAP_TAG_DMA       = 3'h4;
	localparam logic [2:0]  HBAP_TAG_WR        = 3'h5;
	typedef enum logic [1:0] {
		HBAP_REG_ISO,
		HBAP_REG_INT,
		HBAP_REG_ASYNC,
		HBAP_REG_PAYLOAD
	} hbap_region_t;
endpackage : hbap_pkg

// *** verilog/hbap_port.sv ***
`timescale 1ns/100ps
module hbap_port #(
	parameter int RAM_DEPTH = hbap_pkg::HBAP_RAM_WORDS
) (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          reset_n,
	// processor pins
	input  wire logic                          cs_n,
	input  wire logic                          rd_n,
	input  wire logic                          wr_n,
	input  wire logic [17:0]                   addr,
	input  wire logic [31:0]                   data_in,
	output logic [31:0]                        data_out,
	output logic                               data_oe,
	// dma pins
	output logic                               dma_request,
	input  wire logic                          dma_acknowledge,
	// settings from the register file
	input  wire logic [31:0]                   hw_mode,
	input  wire logic [31:0]                   dma_cfg,
	input  wire logic [15:0]                   dma_start_addr,
	input  wire logic [16:0]                   dma_length,
	input  wire logic [6:0]                    dma_burst_bytes,
	input  wire logic [31:0]                   irq_enable,
	// register file access
	output logic                               reg_wr,
	output logic                               reg_rd,
	output logic [15:0]                        reg_addr,
	output logic [31:0]                        reg_wdata,
	input  wire logic [31:0]                   reg_rdata,
	// status
	output logic                               dma_complete_irq_bit,
	output logic                               dma_busy,
	output hbap_pkg::hbap_region_t             mem_region,
	// host engine
	input  wire logic                          eng_req,
	input  wire logic                          eng_we,
	input  wire logic [hbap_pkg::HBAP_IDX_W-1:0] eng_idx,
	input  wire logic [63:0]                   eng_wdata,
	input  wire logic [7:0]                    eng_be,
	output logic                               eng_grant,
	output logic                               eng_rvalid,
	output logic [63:0]                        eng_rdata
);
	import hbap_pkg::*;

	function automatic logic [HBAP_IDX_W-1:0] word_idx(input logic [15:0] a);
		word_idx = HBAP_IDX_W'((a - HBAP_MEM_BASE) >> 3);
	endfunction : word_idx

	function automatic logic [7:0] lane_be(input logic [3:0] lm, input logic [15:0] a, input logic w32);
		logic [2:0] sh;
		sh = w32 ? {a[2], 2'h0} : {a[2:1], 1'h0};
		lane_be = 8'({4'h0, lm} << sh);
	endfunction : lane_be

	// pin synchronisers
	logic        cs_m, cs_s, rd_m, rd_s, wr_m, wr_s, ack_m, ack_s;
	logic [17:0] a_m, a_s;
	logic [31:0] d_m, d_s;
	logic        rd_q, wr_q;
	wire         bus32   = hw_mode[HBAP_BUS32_BIT];
	wire         ack_on  = ack_s ~^ hw_mode[HBAP_DMA_ACKNOWLEDGE_HI_BIT];
	wire         rd_on   = ~rd_s & (~cs_s | ack_on);
	wire         wr_on   = ~wr_s & (~cs_s | ack_on);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{cs_m, cs_s, rd_m, rd_s, wr_m, wr_s} <= 6'h3f;
			{ack_m, ack_s}                       <= 2'h0;
			{a_m, a_s}                           <= 36'h0;
			{d_m, d_s}                           <= 64'h0;
			{rd_q, wr_q}                         <= 2'h0;
		end else begin
			{cs_m, rd_m, wr_m, ack_m} <= {cs_n, rd_n, wr_n, dma_acknowledge};
			{cs_s, rd_s, wr_s, ack_s} <= {cs_m, rd_m, wr_m, ack_m};
			a_m <= addr;
			a_s <= a_m;
			d_m <= data_in;
			d_s <= d_m;
			rd_q <= rd_on;
			wr_q <= wr_on;
		end
	end

	// strobe qualification and decode
	wire        rd_go   = rd_on & ~rd_q;
	wire        wr_go   = wr_on & ~wr_q;
	wire        pio     = ~ack_on & ~cs_s;
	wire [15:0] a_lo    = a_s[15:0];
	wire [1:0]  a_bank  = a_s[17:16];
	wire        is_mem  = a_lo >= HBAP_MEM_BASE;
	wire        is_pref = a_lo[15:2] == HBAP_PREFETCH_OFS[15:2];
	wire [2:0]  step    = bus32 ? 3'h4 : 3'h2;
	wire [3:0]  full_lm = bus32 ? 4'hf : 4'h3;
	wire [63:0] d_lanes = bus32 ? {2{d_s}} : {4{d_s[15:0]}};
	wire [HBAP_IDX_W-1:0] mem_idx = word_idx(a_lo);
	wire        pio_mwr = pio & wr_go & is_mem;
	wire        bank_rd = pio & rd_go & is_mem;
	wire        pref_wr = pio & wr_go & is_pref;

	// prefetch register, halves joined in 16-bit mode
	logic [31:0] pref_reg;
	wire         pref_commit = pref_wr & (bus32 | a_lo[1]);
	wire [31:0]  pref_val    = bus32 ? d_s : {d_s[15:0], pref_reg[15:0]};
	wire [1:0]   pref_bank   = pref_val[17:16];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			pref_reg <= HBAP_PREFETCH_RST;
		else if (pref_wr)
			pref_reg <= (bus32 | a_lo[1]) ? pref_val : {pref_reg[31:16], d_s[15:0]};
	end

	// dma engine state
	logic        en_q, dma_act, dma_wr, dma_hold, dbuf_valid;
	logic [15:0] dma_ptr;
	logic [16:0] dma_rem;
	logic [6:0]  dma_beat;
	logic [31:0] dbuf;
	wire         dma_en     = dma_cfg[HBAP_DMA_EN_BIT];
	wire         dma_go     = dma_en & ~en_q;
	wire         dma_rd_cyc = ack_on & rd_go & dma_act & ~dma_wr;
	wire         dma_wr_cyc = ack_on & wr_go & dma_act & dma_wr;
	wire         beat_go    = dma_rd_cyc | dma_wr_cyc;
	wire [6:0]   burst_raw  = bus32 ? {2'h0, dma_burst_bytes[6:2]} : {1'h0, dma_burst_bytes[6:1]};
	wire [6:0]   burst_cyc  = (burst_raw == 7'h0) ? 7'h1 : burst_raw;
	wire         beat_last  = (dma_beat + 7'h1) >= burst_cyc;
	wire         rem_last   = dma_rem <= {14'h0, step};
	wire         rem_short  = dma_rem < {14'h0, step};
	wire [16:0]  rem_next   = rem_last ? 17'h0 : dma_rem - {14'h0, step};
	wire [3:0]   dma_lm     = rem_short ? 4'((5'h1 << dma_rem[1:0]) - 5'h1) : full_lm;
	wire         dma_request_int   = dma_act & ~dma_hold & (dma_wr | dbuf_valid);
	wire         dbuf_use   = dma_rd_cyc & (bus32 | dma_ptr[1]);

	assign dma_request = dma_request_int ~^ hw_mode[HBAP_DMA_REQUEST_HI_BIT];
	assign dma_busy    = dma_act;

	// ram request slot and write slot
	logic                  op_req, op_we, wait_rd, wr_pend;
	logic [HBAP_IDX_W-1:0] op_idx, wr_idx;
	logic [63:0]           op_wdata, wr_data, ram_rdata;
	logic [7:0]            op_be, wr_be;
	logic [2:0]            op_tag;
	logic [15:0]           op_ptr;
	logic                  op_grant, op_rvalid;
	logic [15:0]           bptr [4];
	logic [31:0]           bdata [4];
	logic [3:0]            bvalid, bhalf, barmed;
	wire  [3:0]            bneed  = barmed & ~bvalid;
	wire                   dfetch = dma_act & ~dma_wr & ~dbuf_valid;
	wire  [1:0]            nb     = bneed[0] ? 2'h0 : bneed[1] ? 2'h1 : bneed[2] ? 2'h2 : 2'h3;
	wire                   issue  = (wr_pend | dfetch | (|bneed)) & ~op_req & ~wait_rd;
	wire  [15:0]           f_ptr  = dfetch ? dma_ptr : bptr[nb];
	wire  [2:0]            f_tag  = dfetch ? HBAP_TAG_DMA : {1'h0, nb};
	wire  [31:0]           r_word = op_ptr[2] ? ram_rdata[63:32] : ram_rdata[31:0];
	wire                   fill   = op_rvalid & wait_rd;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{op_req, op_we, wait_rd} <= 3'h0;
			op_idx   <= '0;
			op_wdata <= 64'h0;
			op_be    <= 8'h0;
			op_tag   <= 3'h0;
			op_ptr   <= 16'h0;
		end else begin
			if (issue) begin
				op_req   <= 1'b1;
				op_we    <= wr_pend;
				op_idx   <= wr_pend ? wr_idx : word_idx(f_ptr);
				op_wdata <= wr_data;
				op_be    <= wr_be;
				op_tag   <= wr_pend ? HBAP_TAG_WR : f_tag;
				op_ptr   <= f_ptr;
			end else if (op_grant) begin
				op_req  <= 1'b0;
				wait_rd <= ~op_we;
			end else if (fill) begin
				wait_rd <= 1'b0;
			end
		end
	end

	// write slot, new write wins over the clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			wr_idx  <= '0;
			wr_data <= 64'h0;
			wr_be   <= 8'h0;
		end else begin
			if (issue && wr_pend)
				wr_pend <= 1'b0;
			if (pio_mwr || dma_wr_cyc) begin
				wr_pend <= 1'b1;
				wr_idx  <= dma_wr_cyc ? word_idx(dma_ptr) : mem_idx;
				wr_data <= d_lanes;
				wr_be   <= dma_wr_cyc ? lane_be(dma_lm, dma_ptr, bus32) : lane_be(full_lm, a_lo, bus32);
			end
		end
	end

	// prefetch banks
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bvalid <= 4'h0;
			bhalf  <= 4'h0;
			barmed <= 4'h0;
			for (int b = 0; b < 4; b++) begin
				bptr[b]  <= 16'h0;
				bdata[b] <= 32'h0;
			end
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (pref_commit && pref_bank == 2'(b)) begin
					bptr[b]   <= {pref_val[15:2], 2'h0};
					bvalid[b] <= 1'b0;
					bhalf[b]  <= 1'b0;
					barmed[b] <= 1'b1;
				end else if (bank_rd && a_bank == 2'(b)) begin
					if (bus32 || bhalf[b]) begin
						bptr[b]   <= bptr[b] + 16'h4;
						bvalid[b] <= 1'b0;
						bhalf[b]  <= 1'b0;
					end else begin
						bhalf[b] <= 1'b1;
					end
				end else if (fill && op_tag == 3'(b) && op_ptr == bptr[b]) begin
					bdata[b]  <= r_word;
					bvalid[b] <= 1'b1;
				end
			end
		end
	end

	// dma counters and request control
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{en_q, dma_act, dma_wr, dma_hold, dbuf_valid} <= 5'h0;
			dma_ptr  <= 16'h0;
			dma_rem  <= 17'h0;
			dma_beat <= 7'h0;
			dbuf     <= 32'h0;
			dma_complete_irq_bit <= 1'b0;
		end else begin
			en_q <= dma_en;
			dma_complete_irq_bit <= beat_go & rem_last & irq_enable[HBAP_DMA_IRQ_BIT];
			if (dma_go) begin
				dma_act  <= dma_length != 17'h0;
				dma_wr   <= dma_cfg[HBAP_DMA_WR_BIT];
				dma_ptr  <= bus32 ? {dma_start_addr[15:2], 2'h0} : {dma_start_addr[15:1], 1'h0};
				dma_rem  <= dma_length;
				dma_beat <= 7'h0;
				dma_hold <= 1'b0;
			end else if (beat_go) begin
				dma_ptr <= dma_ptr + {13'h0, step};
				dma_rem <= rem_next;
				if (beat_last || rem_last) begin
					dma_beat <= 7'h0;
					dma_hold <= 1'b1;
				end else begin
					dma_beat <= dma_beat + 7'h1;
				end
				if (rem_last)
					dma_act <= 1'b0;
			end else if (dma_hold && !ack_on) begin
				dma_hold <= 1'b0;
			end
			if (dma_go || dbuf_use)
				dbuf_valid <= 1'b0;
			else if (fill && op_tag == HBAP_TAG_DMA && op_ptr[15:2] == dma_ptr[15:2] && dma_act) begin
				dbuf       <= r_word;
				dbuf_valid <= 1'b1;
			end
		end
	end

	// read data and register strobes
	wire [31:0] bword    = bdata[a_bank];
	wire [31:0] bank_out = bus32 ? bword : {16'h0, bhalf[a_bank] ? bword[31:16] : bword[15:0]};
	wire [31:0] dma_out  = bus32 ? dbuf : {16'h0, dma_ptr[1] ? dbuf[31:16] : dbuf[15:0]};
	wire [31:0] reg_src  = is_pref ? pref_reg : reg_rdata;
	wire [31:0] reg_out  = bus32 ? reg_src : {16'h0, a_lo[1] ? reg_src[31:16] : reg_src[15:0]};
	wire [31:0] rd_mux   = ack_on ? dma_out : is_mem ? bank_out : reg_out;
	wire        reg_acc  = pio & ~is_mem & ~is_pref;
	hbap_region_t a_region;
	assign a_region = (a_lo >= HBAP_PAYLOAD_BASE) ? HBAP_REG_PAYLOAD :
		(a_lo >= HBAP_ASYNC_BASE) ? HBAP_REG_ASYNC :
		(a_lo >= HBAP_INT_BASE) ? HBAP_REG_INT : HBAP_REG_ISO;
	assign data_oe = rd_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_out   <= 32'h0;
			{reg_wr, reg_rd} <= 2'h0;
			reg_addr   <= 16'h0;
			reg_wdata  <= 32'h0;
			mem_region <= HBAP_REG_ISO;
		end else begin
			if (rd_go)
				data_out <= rd_mux;
			reg_wr <= reg_acc & wr_go;
			reg_rd <= reg_acc & rd_go;
			if (reg_acc && (wr_go || rd_go)) begin
				reg_addr  <= a_lo;
				reg_wdata <= d_s;
			end
			if (pio_mwr || bank_rd)
				mem_region <= a_region;
		end
	end

	hbap_ram #(
		.DEPTH (RAM_DEPTH),
		.AW    (HBAP_IDX_W)
	) u_ram (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.a_req    (op_req),
		.a_we     (op_we),
		.a_idx    (op_idx),
		.a_wdata  (op_wdata),
		.a_be     (op_be),
		.a_grant  (op_grant),
		.a_rvalid (op_rvalid),
		.b_req    (eng_req),
		.b_we     (eng_we),
		.b_idx    (eng_idx),
		.b_wdata  (eng_wdata),
		.b_be     (eng_be),
		.b_grant  (eng_grant),
		.b_rvalid (eng_rvalid),
		.rdata    (ram_rdata)
	);
	assign eng_rdata = ram_rdata;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence dma_last_beat;
		beat_go && beat_last && !rem_last;
	endsequence
	sequence dma_final;
		beat_go && rem_last;
	endsequence

	dma_request_start_a: assert property ($rose(dma_en) && dma_cfg[HBAP_DMA_WR_BIT] && dma_length != 17'h0
		|=> dma_request == hw_mode[HBAP_DMA_REQUEST_HI_BIT])
		else $error("request not raised on dma enable");
	burst_drop_a: assert property (dma_last_beat |=> !dma_request_int && dma_act)
		else $error("request not dropped at burst end");
	dma_request_rearm_a: assert property (dma_hold && !ack_on && dma_act && (dma_wr || dbuf_valid) && !dma_go |=> dma_request_int)
		else $error("request not raised after acknowledge release");
	count_end_a: assert property (dma_final |=> !dma_act && !dma_request_int ##1 (dma_go || !dma_request_int))
		else $error("request active after byte count ended");
	done_irq_a: assert property (dma_final |=> dma_complete_irq_bit == $past(irq_enable[HBAP_DMA_IRQ_BIT]))
		else $error("completion interrupt bit wrong");
	pio_keeps_dma_a: assert property (pio && (rd_go || wr_go) && !dma_go
		|=> $stable(dma_ptr) && $stable(dma_rem))
		else $error("pio access disturbed dma counters");
	odd_bytes_a: assert property (dma_wr_cyc && rem_short
		|=> wr_pend && $countones(wr_be) == int'($past(dma_rem[1:0])))
		else $error("odd tail wrote wrong byte count");
	write_addr_a: assert property (pio_mwr |=> wr_pend && wr_idx == $past(mem_idx))
		else $error("memory write index not taken from address");
	bank_step_a: assert property (bank_rd && bus32 |=> bptr[$past(a_bank)] == $past(bptr[a_bank]) + 16'h4)
		else $error("bank pointer did not advance by four");
	prefetch_out_a: assert property (bank_rd && bus32 && bvalid[a_bank] |=> data_out == $past(bword))
		else $error("prefetched data not returned");
	reg_exact_a: assert property (reg_acc && rd_go |=> reg_rd && reg_addr == $past(a_lo))
		else $error("register address not taken exactly");
	strobe_qual_a: assert property ($rose(reg_wr) |-> $past(!cs_s && !ack_on))
		else $error("register write without chip select");
	pref_load_a: assert property (pref_commit |=> barmed[$past(pref_bank)] && !bvalid[$past(pref_bank)])
		else $error("prefetch write did not load bank");
endmodule : hbap_port

// *** verilog/hbap_ram.sv ***
`timescale 1ns/100ps
module hbap_ram #(
	parameter int DEPTH = 8192,
	parameter int AW    = 13
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	// processor side
	input  wire logic          a_req,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_idx,
	input  wire logic [63:0]   a_wdata,
	input  wire logic [7:0]    a_be,
	output logic               a_grant,
	output logic               a_rvalid,
	// engine side
	input  wire logic          b_req,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_idx,
	input  wire logic [63:0]   b_wdata,
	input  wire logic [7:0]    b_be,
	output logic               b_grant,
	output logic               b_rvalid,
	// shared read data
	output logic [63:0]        rdata
);
	logic [63:0]   mem [DEPTH];
	logic          last_a;
	wire           both    = a_req & b_req;
	wire           we      = a_grant ? a_we : b_we;
	wire [AW-1:0]  idx     = a_grant ? a_idx : b_idx;
	wire [63:0]    wdata   = a_grant ? a_wdata : b_wdata;
	wire [7:0]     be      = a_grant ? a_be : b_be;
	wire           any_gnt = a_grant | b_grant;

	// alternate when both ask in one cycle
	assign a_grant = a_req & (~both | ~last_a);
	assign b_grant = b_req & ~a_grant;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			last_a   <= 1'b0;
			a_rvalid <= 1'b0;
			b_rvalid <= 1'b0;
		end else begin
			if (any_gnt)
				last_a <= a_grant;
			a_rvalid <= a_grant & ~a_we;
			b_rvalid <= b_grant & ~b_we;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (any_gnt && we) begin
			for (int i = 0; i < 8; i++) begin
				if (be[i])
					mem[idx][i*8 +: 8] <= wdata[i*8 +: 8];
			end
		end
		if (any_gnt && !we)
			rdata <= mem[idx];
	end

	ram_excl_a: assert property (@(posedge clk_sys) disable iff (!reset_n) !(a_grant && b_grant))
		else $error("both ram ports granted");
	ram_fair_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(both && !a_grant) |=> (a_req |-> a_grant))
		else $error("processor side starved by engine");
endmodule : hbap_ram
